// *** host_model.sv ***
// Host side of the serial link: one status read per control-1 access.
// Assumes the bench calls it away from the rising edge of clk.
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output logic access_strobe,
  input wire logic [supply_status_pkg::STATUS_W-1:0] status_word
);
  import supply_status_pkg::*;
  initial access_strobe = 1'b0;
  // Strobe lasts one cycle; the word is loaded at the edge that takes it
  task automatic read_status(output logic [STATUS_W-1:0] w);
    @(negedge clk);
    access_strobe = 1'b1;
    @(negedge clk);
    access_strobe = 1'b0;
    w = status_word;
  endtask : read_status
endmodule : host_model

// *** supply_mode_status_register.sv ***
// Status word of the power manager, loaded on every control-1 access.
// Assumes conditions arrive as clean synchronous levels or pulses, and the
// serial engine shifts status_word out of the frame after access_strobe.
`timescale 1ns/1ps
module supply_mode_status_register (
  input wire logic clk,
  input wire logic sys_rst,
  input wire supply_status_pkg::cond_t cond,
  input wire supply_status_pkg::mode_t mode_req,
  input wire logic mode_req_valid,
  input wire logic access_strobe,
  output logic [supply_status_pkg::STATUS_W-1:0] status_word,
  output logic outputs_off,
  output logic reg1_off,
  output logic wake_event
);
  import supply_status_pkg::*;

  state_t s_reg;
  state_t s_next;
  logic [STATUS_W-1:0] live;

  always_comb begin
    s_next = s_reg;
    s_next.wake = 1'b0;
    // Mode: a read in regulator-1 standby is a wake-up
    if (access_strobe && s_reg.mode == MODE_REG1_STBY) begin
      s_next.mode = MODE_ACTIVE; // R10
      s_next.wake = 1'b1;
    end else if (mode_req_valid) begin
      s_next.mode = mode_req; // R9
    end
    // Regulator glitch filter and turn-on check, counters saturate
    if (cond.reg1_low) begin
      if (s_reg.r1_low_cnt != FILT_W'(FAIL_FILT_CYC))
        s_next.r1_low_cnt = s_reg.r1_low_cnt + 1'b1;
    end else begin
      s_next.r1_low_cnt = '0;
    end
    if (cond.reg2_low) begin
      if (s_reg.r2_low_cnt != FILT_W'(FAIL_FILT_CYC))
        s_next.r2_low_cnt = s_reg.r2_low_cnt + 1'b1;
    end else begin
      s_next.r2_low_cnt = '0;
    end
    if (!cond.reg1_on)
      s_next.r1_on_cnt = '0;
    else if (s_reg.r1_on_cnt != TURNON_W'(TURNON_CHECK_CYC))
      s_next.r1_on_cnt = s_reg.r1_on_cnt + 1'b1;
    if (!cond.reg2_on)
      s_next.r2_on_cnt = '0;
    else if (s_reg.r2_on_cnt != TURNON_W'(TURNON_CHECK_CYC))
      s_next.r2_on_cnt = s_reg.r2_on_cnt + 1'b1;
    s_next.r1_fail = cond.reg1_low &&
      (s_reg.r1_low_cnt == FILT_W'(FAIL_FILT_CYC) ||
       s_reg.r1_on_cnt == TURNON_W'(TURNON_CHECK_CYC - 1)); // R7
    s_next.r2_fail = cond.reg2_low &&
      (s_reg.r2_low_cnt == FILT_W'(FAIL_FILT_CYC) ||
       s_reg.r2_on_cnt == TURNON_W'(TURNON_CHECK_CYC - 1)); // R8
    // Restart attempts after thermal shutdown
    if (cond.restart_ok)
      s_next.restarts = '0;
    else if (cond.restart_fail && s_reg.restarts != RESTART_MAX)
      s_next.restarts = s_reg.restarts + 1'b1; // R11
    // Watchdog time-outs; the 15th failure enters forced sleep and clears
    if (cond.wdog_valid_wdog_trigger_mirror)
      s_next.wdog_cnt = '0; // R13
    else if (cond.wdog_timeout) begin
      if (s_reg.wdog_cnt == WDOG_MAX - 4'h1)
        s_next.wdog_cnt = '0; // R13
      else
        s_next.wdog_cnt = s_reg.wdog_cnt + 1'b1; // R12
    end
    s_next.outs_off = cond.temp_shut1 || cond.temp_shut2; // R5
    s_next.reg1_off = cond.temp_shut2; // R6
    // Sample the live word only at an access, so a frame shifts a stable value
    if (access_strobe)
      s_next.word = live; // R1
  end

  always_comb begin
    live = STATUS_RESET; // R16
    live[BIT_OV] = cond.bat_overvolt; // R2
    live[BIT_UV] = cond.bat_undervolt; // R3
    live[BIT_TW] = cond.temp_warn; // R4
    live[BIT_THERMAL_SHUTDOWN_LVL1] = cond.temp_shut1; // R5
    live[BIT_THERMAL_SHUTDOWN_LVL2] = cond.temp_shut2; // R6
    live[BIT_REG1_FAIL] = s_reg.r1_fail; // R7
    live[BIT_REG2_FAIL] = s_reg.r2_fail; // R8
    // A wake read reports the mode it lands in
    live[BIT_MODE_LO +: 2] = (s_reg.mode == MODE_REG1_STBY) ?
      MODE_ACTIVE : s_reg.mode; // R10
    live[BIT_RESTART_LO +: 3] = s_reg.restarts; // R11
    live[BIT_WDOG_LO +: 4] = s_reg.wdog_cnt; // R12
    live[BIT_WDOG_TRIGGER_MIRROR] = cond.wdog_wdog_trigger_mirror_bit; // R14
    live[BIT_LIN_DOM] = cond.lin_dom_to; // R15
    live[BIT_LIN_BAT] = cond.lin_lin_short_battery_flag; // R15
    live[BIT_LIN_GND] = cond.lin_lin_short_ground_flag; // R15
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_reg <= '0;
      s_reg.word <= STATUS_RESET; // R16
      s_reg.mode <= MODE_ACTIVE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign status_word = s_reg.word;
  assign outputs_off = s_reg.outs_off;
  assign reg1_off = s_reg.reg1_off;
  assign wake_event = s_reg.wake;

  reserved_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    status_word[21:20] == 2'h0) else $error("reserved bits set"); // R16
  word_load_a: assert property (@(posedge clk) disable iff (sys_rst)
    access_strobe |=> status_word[BIT_WDOG_TRIGGER_MIRROR] == $past(cond.wdog_wdog_trigger_mirror_bit))
    else $error("trigger mirror wrong"); // R14
  word_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !access_strobe |=> $stable(status_word))
    else $error("word changed without access"); // R1
  wake_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
    (access_strobe && s_reg.mode == MODE_REG1_STBY) |=>
    status_word[8:7] == 2'h0 && s_reg.mode == MODE_ACTIVE && wake_event)
    else $error("wake read wrong"); // R10
  thermal_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    cond.temp_shut2 |=> reg1_off && outputs_off)
    else $error("shutdown 2 outputs on"); // R6
  thermal_lvl1_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cond.temp_shut1 && !cond.temp_shut2) |=> outputs_off && !reg1_off)
    else $error("shutdown 1 wrong"); // R5
  wdog_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    cond.wdog_valid_wdog_trigger_mirror |=> s_reg.wdog_cnt == 4'h0)
    else $error("wdog count not cleared"); // R13
  wdog_count_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cond.wdog_timeout && !cond.wdog_valid_wdog_trigger_mirror && s_reg.wdog_cnt < 4'hE)
    |=> s_reg.wdog_cnt == $past(s_reg.wdog_cnt) + 4'h1)
    else $error("wdog count not incremented"); // R12
  reg1_glitch_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!cond.reg1_low ##1 cond.reg1_low [*2] ##1 !cond.reg1_low
     && s_reg.r1_on_cnt > 20'h1) |=> !s_reg.r1_fail)
    else $error("short dip flagged"); // R7
  flags_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
    access_strobe |=> status_word[2:0] == {$past(cond.temp_warn),
    $past(cond.bat_undervolt), $past(cond.bat_overvolt)})
    else $error("supply flags wrong"); // R4
  tsd_flags_a: assert property (@(posedge clk) disable iff (sys_rst)
    access_strobe |=> status_word[4:3] == {$past(cond.temp_shut2),
    $past(cond.temp_shut1)})
    else $error("shutdown flags wrong"); // R5
  lin_flags_a: assert property (@(posedge clk) disable iff (sys_rst)
    access_strobe |=> status_word[19:17] == {$past(cond.lin_dom_to),
    $past(cond.lin_lin_short_battery_flag), $past(cond.lin_lin_short_ground_flag)})
    else $error("LIN flags wrong"); // R15
  mode_load_a: assert property (@(posedge clk) disable iff (sys_rst)
    (mode_req_valid && !(access_strobe && s_reg.mode == MODE_REG1_STBY))
    |=> s_reg.mode == $past(mode_req))
    else $error("mode not loaded"); // R9
  reg1_fail_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cond.reg1_low && s_reg.r1_low_cnt == FILT_W'(FAIL_FILT_CYC))
    |=> s_reg.r1_fail)
    else $error("reg1 fail missed"); // R7
  reg2_fail_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cond.reg2_low && s_reg.r2_low_cnt == FILT_W'(FAIL_FILT_CYC))
    |=> s_reg.r2_fail)
    else $error("reg2 fail missed"); // R8
  restart_clr_a: assert property (@(posedge clk) disable iff (sys_rst)
    cond.restart_ok |=> s_reg.restarts == 3'h0)
    else $error("restart count not cleared"); // R11
  restart_sat_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cond.restart_fail && !cond.restart_ok && s_reg.restarts == 3'h7)
    |=> s_reg.restarts == 3'h7)
    else $error("restart count wrapped"); // R11
  wdog_sleep_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cond.wdog_timeout && !cond.wdog_valid_wdog_trigger_mirror && s_reg.wdog_cnt == 4'hE)
    |=> s_reg.wdog_cnt == 4'h0)
    else $error("forced sleep did not clear"); // R13
endmodule : supply_mode_status_register

// *** supply_status_pkg.sv ***
// Constants and carrier types for the supply, mode and status word block.
// Assumes one 250 MHz clock, and that the serial front end delivers one
// access strobe per frame that addresses control register 1.
// How it works
// [R1] Status word is sampled out on every access to control register 1.
// [R2] Bit 0 flags battery supply overvoltage failure.
// [R3] Bit 1 flags battery supply undervoltage failure.
// [R4] Bit 2 flags die temperature above the warning level.
// [R5] Bit 3 flags first shutdown; all outputs but regulator 1 go off.
// [R6] Bit 4 flags second shutdown; every output including regulator 1 off.
// [R7] Bit 5 flags regulator 1 low over 2 us or still low 4 ms on.
// [R8] Bit 6 flags regulator 2 low over 2 us or still low 4 ms on.
// [R9] Bits 8..7 hold mode: active, regulator-1 standby, battery standby, flash.
// [R10] A status read in regulator-1 standby wakes to active; mode reads 00.
// [R11] Bits 11..9 count failed restarts after thermal shutdown.
// [R12] Bits 15..12 count watchdog time-outs.
// [R13] Time-out count clears on valid trigger or forced sleep entry.
// [R14] Bit 16 mirrors the watchdog trigger bit of control register 0.
// [R15] Bits 19, 18, 17: LIN dominant time-out, short battery, short ground.
// [R16] Bits 21..20 read zero; whole word is zero after reset.
package supply_status_pkg;
  localparam int STATUS_W = 22;
  localparam int CLK_MHZ = 250;
  localparam int FAIL_FILT_NS = 2000;
  localparam int TURNON_CHECK_US = 4000;
  // Least time: round up
  localparam int FAIL_FILT_CYC = (FAIL_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int TURNON_CHECK_CYC = TURNON_CHECK_US * CLK_MHZ;
  localparam int FILT_W = 10;
  localparam int TURNON_W = 20;
  localparam int BIT_OV = 0;
  localparam int BIT_UV = 1;
  localparam int BIT_TW = 2;
  localparam int BIT_THERMAL_SHUTDOWN_LVL1 = 3;
  localparam int BIT_THERMAL_SHUTDOWN_LVL2 = 4;
  localparam int BIT_REG1_FAIL = 5;
  localparam int BIT_REG2_FAIL = 6;
  localparam int BIT_MODE_LO = 7;
  localparam int BIT_RESTART_LO = 9;
  localparam int BIT_WDOG_LO = 12;
  localparam int BIT_WDOG_TRIGGER_MIRROR = 16;
  localparam int BIT_LIN_GND = 17;
  localparam int BIT_LIN_BAT = 18;
  localparam int BIT_LIN_DOM = 19;
  localparam logic [21:0] STATUS_RESET = 22'h000000;
  localparam logic [3:0] WDOG_MAX = 4'hF;
  localparam logic [2:0] RESTART_MAX = 3'h7;

  typedef enum logic [1:0] {
    MODE_ACTIVE = 2'h0,
    MODE_REG1_STBY = 2'h1,
    MODE_BAT_STBY = 2'h2,
    MODE_FLASH = 2'h3
  } mode_t;

  typedef struct packed {
    logic bat_overvolt;
    logic bat_undervolt;
    logic temp_warn;
    logic temp_shut1;
    logic temp_shut2;
    logic reg1_low;
    logic reg1_on;
    logic reg2_low;
    logic reg2_on;
    logic restart_fail;
    logic restart_ok;
    logic wdog_timeout;
    logic wdog_valid_wdog_trigger_mirror;
    logic wdog_wdog_trigger_mirror_bit;
    logic lin_dom_to;
    logic lin_lin_short_battery_flag;
    logic lin_lin_short_ground_flag;
  } cond_t;

  typedef struct packed {
    logic [STATUS_W-1:0] word;
    mode_t mode;
    logic [2:0] restarts;
    logic [3:0] wdog_cnt;
    logic [FILT_W-1:0] r1_low_cnt;
    logic [FILT_W-1:0] r2_low_cnt;
    logic [TURNON_W-1:0] r1_on_cnt;
    logic [TURNON_W-1:0] r2_on_cnt;
    logic r1_fail;
    logic r2_fail;
    logic outs_off;
    logic reg1_off;
    logic wake;
  } state_t;
endpackage : supply_status_pkg

// *** testbench.sv ***
// Self-checking bench for the supply, mode and status word block.
// Assumes the host model issues the reads; other inputs change at negedge.
`timescale 1ns/1ps
module testbench;
  import supply_status_pkg::*;
  logic clk, sys_rst, mode_req_valid, access_strobe;
  logic outputs_off, reg1_off, wake_event;
  cond_t cond, p;
  mode_t mode_req;
  logic [STATUS_W-1:0] status_word, w;
  int err_total, compares;
  supply_mode_status_register supply_mode_status_register_inst (
    .clk(clk), .sys_rst(sys_rst), .cond(cond), .mode_req(mode_req),
    .mode_req_valid(mode_req_valid), .access_strobe(access_strobe),
    .status_word(status_word), .outputs_off(outputs_off),
    .reg1_off(reg1_off), .wake_event(wake_event));
  host_model host_model_inst (.clk(clk), .access_strobe(access_strobe),
    .status_word(status_word));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [STATUS_W-1:0] got, exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic pulse(input cond_t m, input int n);
    repeat (n) begin
      @(negedge clk);
      cond = cond | m;
      @(negedge clk);
      cond = cond & ~m;
    end
  endtask : pulse
  task automatic t_live;
    cond.bat_overvolt = 1'b1;
    cond.temp_warn = 1'b1;
    cond.temp_shut1 = 1'b1;
    cond.wdog_wdog_trigger_mirror_bit = 1'b1;
    cond.lin_lin_short_battery_flag = 1'b1;
    host_model_inst.read_status(w);
    check(w, 22'h05000D);
    check({outputs_off, reg1_off}, 22'h000002);
    cond = '0;
    cond.bat_undervolt = 1'b1;
    cond.temp_shut2 = 1'b1;
    cond.lin_dom_to = 1'b1;
    cond.lin_lin_short_ground_flag = 1'b1;
    host_model_inst.read_status(w);
    check(w, 22'h0A0012);
    check({outputs_off, reg1_off}, 22'h000003);
    cond = '0;
  endtask : t_live
  task automatic t_mode(input mode_t m, input logic [21:0] exp, wk);
    @(negedge clk);
    mode_req = m;
    mode_req_valid = 1'b1;
    @(negedge clk);
    mode_req_valid = 1'b0;
    host_model_inst.read_status(w);
    check(w, exp);
    check({21'h0, wake_event}, wk);
  endtask : t_mode
  task automatic t_count;
    p = '0;
    p.restart_fail = 1'b1;
    pulse(p, 3);
    p = '0;
    p.wdog_timeout = 1'b1;
    pulse(p, 5);
    host_model_inst.read_status(w);
    check(w, 22'h005600);
    p = '0;
    p.wdog_valid_wdog_trigger_mirror = 1'b1;
    p.restart_ok = 1'b1;
    pulse(p, 1);
    host_model_inst.read_status(w);
    check(w, 22'h000000);
    p = '0;
    p.wdog_timeout = 1'b1;
    pulse(p, 14);
    host_model_inst.read_status(w);
    check(w, 22'h00E000);
    pulse(p, 1);
    host_model_inst.read_status(w);
    check(w, 22'h000000);
  endtask : t_count
  task automatic t_regfail;
    // A two-cycle dip is far below the filter and must not flag
    @(negedge clk);
    cond.reg1_on = 1'b1;
    repeat (3) @(negedge clk);
    cond.reg1_low = 1'b1;
    repeat (2) @(negedge clk);
    cond.reg1_low = 1'b0;
    host_model_inst.read_status(w);
    check(w, 22'h000000);
    // Low for longer than the 2 us filter, well inside the turn-on window
    @(negedge clk);
    cond.reg1_on = 1'b1;
    cond.reg2_on = 1'b1;
    cond.reg1_low = 1'b1;
    cond.reg2_low = 1'b1;
    repeat (520) @(negedge clk);
    host_model_inst.read_status(w);
    check(w, 22'h000060);
    cond = '0;
    repeat (2) @(negedge clk);
    host_model_inst.read_status(w);
    check(w, 22'h000000);
  endtask : t_regfail
  task automatic wrap_up;
    if (err_total == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    wrap_up();
  end
  initial begin
    cond = '0;
    mode_req = MODE_ACTIVE;
    mode_req_valid = 1'b0;
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    host_model_inst.read_status(w);
    check(w, 22'h000000);
    t_live();
    t_mode(MODE_FLASH, 22'h000180, 22'h0);
    t_mode(MODE_BAT_STBY, 22'h000100, 22'h0);
    t_mode(MODE_REG1_STBY, 22'h000000, 22'h1);
    host_model_inst.read_status(w);
    check(w, 22'h000000);
    t_count();
    t_regfail();
    wrap_up();
  end
endmodule : testbench
